/* File: hw/laser_device.sv */
// How it works
// - No output while enable is released.
// - Host asserts enable only after supply up.
// - Fault clears only after release then reassert.
// - Enable input is not a safety interlock.
// - Fault output high while fault latched.
// - Output only while pulse command high.
// - Duty flag high on duty or width excess.
// - Duty flag marks inhibited part, low otherwise.
// - Reflection flag high while reflection protection acts.
// - Reflection flag marks inhibited part, low otherwise.
// - Duty is width over start-to-start period, times 100.
// - Overlong pulses truncated to maximum width.
// - Temperature and shutter faults latch and shut down.
`timescale 1ns/1ps
`default_nettype none

module laser_device #(
  parameter int unsigned max_width_cycles = laser_pkg::MAX_WIDTH_CYC
) (
  input wire logic clock,
  input wire logic srst,
  laser_link_if.device link,
  input wire logic temp_fault,
  input wire logic shutter_fault,
  input wire logic refl_over,
  output logic laser_on
);
  import laser_pkg::*;

  localparam logic [CNT_W-1:0] MAX_WIDTH = CNT_W'(max_width_cycles);
  localparam logic [6:0] DUTY_SCALE_W = 7'(DUTY_SCALE);
  localparam logic [6:0] MAX_DUTY_W = 7'(MAX_DUTY_PCT);
  // Synchroniser resets to the pins' idle levels, enable released, so no false enable
  localparam logic [DS_W-1:0] SYNC_IDLE = DS_W'(2 ** DS_ENABLE_N);

  // Input synchroniser: first stage feeds only the second
  logic [DS_W-1:0] sync1_q;
  logic [DS_W-1:0] sync2_q;
  logic [DS_W-1:0] pins;

  assign pins[DS_ENABLE_N] = link.enable_n;
  assign pins[DS_MOD] = link.modulation;
  assign pins[DS_TEMP] = temp_fault;
  assign pins[DS_SHUTTER] = shutter_fault;
  assign pins[DS_REFL] = refl_over;

  always_ff @(posedge clock) begin
    if (srst) begin
      sync1_q <= SYNC_IDLE;
      sync2_q <= SYNC_IDLE;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  logic enabled;
  logic mod;
  logic fault_cond;
  logic refl;

  // Enable pin is asserted by pulling it to return, hence active low
  assign enabled = ~sync2_q[DS_ENABLE_N] & ~srst;
  assign mod = sync2_q[DS_MOD];
  assign fault_cond = sync2_q[DS_TEMP] | sync2_q[DS_SHUTTER];
  assign refl = sync2_q[DS_REFL];

  // Run state with latched fault
  dev_state_e state_q;
  dev_state_e state_d;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      DEV_OFF: begin
        if (fault_cond) begin
          state_d = DEV_FAULT;
        end else if (enabled) begin
          state_d = DEV_RUN;
        end
      end
      DEV_RUN: begin
        if (fault_cond) begin
          state_d = DEV_FAULT;
        end else if (!enabled) begin
          state_d = DEV_OFF;
        end
      end
      DEV_FAULT: begin
        if (!enabled) begin
          state_d = DEV_ARMED;
        end
      end
      DEV_ARMED: begin
        if (enabled) begin
          // Condition still present on reassert keeps the fault latched
          state_d = fault_cond ? DEV_FAULT : DEV_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= DEV_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Pulse width and period measurement
  logic mod_prev_q;
  logic mod_prev_d;
  logic [CNT_W-1:0] width_q;
  logic [CNT_W-1:0] width_d;
  logic [CNT_W-1:0] period_q;
  logic [CNT_W-1:0] period_d;
  logic [CNT_W-1:0] last_period_q;
  logic [CNT_W-1:0] last_period_d;
  logic seen_rise_q;
  logic seen_rise_d;
  logic have_period_q;
  logic have_period_d;
  logic rise;

  assign rise = mod & ~mod_prev_q;

  always_comb begin
    mod_prev_d = mod;
    seen_rise_d = seen_rise_q | rise;
    have_period_d = have_period_q | (rise & seen_rise_q);
    last_period_d = last_period_q;
    if (rise) begin
      // Period runs from one pulse start to the next
      period_d = CNT_W'(1);
      last_period_d = period_q;
    end else if (period_q != CNT_MAX) begin
      period_d = period_q + CNT_W'(1);
    end else begin
      period_d = period_q;
    end
    if (!mod) begin
      width_d = '0;
    end else if (width_q != CNT_MAX) begin
      width_d = width_q + CNT_W'(1);
    end else begin
      width_d = width_q;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      mod_prev_q <= 1'b0;
      width_q <= '0;
      period_q <= '0;
      last_period_q <= '0;
      seen_rise_q <= 1'b0;
      have_period_q <= 1'b0;
    end else begin
      mod_prev_q <= mod_prev_d;
      width_q <= width_d;
      period_q <= period_d;
      last_period_q <= last_period_d;
      seen_rise_q <= seen_rise_d;
      have_period_q <= have_period_d;
    end
  end

  // Limit checks; width_q counts pulse-command cycles of the current pulse already elapsed
  logic width_viol;
  logic duty_viol;
  logic [CNT_W+6:0] on_scaled;
  logic [CNT_W+6:0] period_scaled;

  assign on_scaled = (CNT_W+7)'(width_q) * (CNT_W+7)'(DUTY_SCALE_W);
  assign period_scaled = (CNT_W+7)'(last_period_q) * (CNT_W+7)'(MAX_DUTY_W);
  assign width_viol = mod & (width_q >= MAX_WIDTH);
  assign duty_viol = mod & have_period_q & (on_scaled >= period_scaled);

  // Registered outputs
  logic laser_on_q;
  logic laser_on_d;
  logic fault_q;
  logic fault_d;
  logic duty_flag_q;
  logic duty_flag_d;
  logic refl_flag_q;
  logic refl_flag_d;
  logic running;

  assign running = (state_q == DEV_RUN) & enabled;

  always_comb begin
    fault_d = (state_d == DEV_FAULT) | (state_d == DEV_ARMED);
    duty_flag_d = mod & (width_viol | duty_viol);
    refl_flag_d = mod & running & refl;
    laser_on_d = running & mod & ~width_viol & ~duty_viol & ~refl;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      laser_on_q <= 1'b0;
      fault_q <= 1'b0;
      duty_flag_q <= 1'b0;
      refl_flag_q <= 1'b0;
    end else begin
      laser_on_q <= laser_on_d;
      fault_q <= fault_d;
      duty_flag_q <= duty_flag_d;
      refl_flag_q <= refl_flag_d;
    end
  end

  assign laser_on = laser_on_q;
  assign link.system_fault = fault_q;
  assign link.duty_limit_flag = duty_flag_q;
  assign link.reflection_limit_flag = refl_flag_q;

endmodule : laser_device

`default_nettype wire

/* File: hw/laser_host.sv */
`timescale 1ns/1ps
`default_nettype none

module laser_host (
  input wire logic clock,
  input wire logic srst,
  laser_link_if.host link,
  input wire logic power_ok,
  input wire logic run_req,
  input wire logic clear_req,
  input wire logic [laser_pkg::CNT_W-1:0] pulse_width,
  input wire logic [laser_pkg::CNT_W-1:0] pulse_period,
  output logic fault_seen,
  output logic duty_warn,
  output logic refl_warn
);
  import laser_pkg::*;

  localparam logic [CNT_W-1:0] CLEAR_OPEN = CNT_W'(CLEAR_OPEN_CYC);

  // Device status and supply good come from outside the clock domain
  logic [HS_W-1:0] sync1_q;
  logic [HS_W-1:0] sync2_q;
  logic [HS_W-1:0] pins;

  assign pins[HS_FAULT] = link.system_fault;
  assign pins[HS_DUTY] = link.duty_limit_flag;
  assign pins[HS_REFL] = link.reflection_limit_flag;
  assign pins[HS_POWER] = power_ok;

  always_ff @(posedge clock) begin
    if (srst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  host_state_e state_q;
  host_state_e state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic enable_n_q;
  logic enable_n_d;
  logic mod_q;
  logic mod_d;
  logic power_up;

  assign power_up = sync2_q[HS_POWER];

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      HOST_IDLE: begin
        cnt_d = '0;
        // Enable only once the supply is up
        if (run_req && power_up) begin
          state_d = HOST_RUN;
        end
      end
      HOST_RUN: begin
        if (!run_req || !power_up) begin
          state_d = HOST_IDLE;
          cnt_d = '0;
        end else if (clear_req) begin
          state_d = HOST_CLEAR;
          cnt_d = '0;
        end else if (cnt_q + CNT_W'(1) >= pulse_period) begin
          cnt_d = '0;
        end else begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
      HOST_CLEAR: begin
        // Hold enable released, then reassert
        if (cnt_q + CNT_W'(1) >= CLEAR_OPEN) begin
          state_d = power_up ? HOST_RUN : HOST_IDLE;
          cnt_d = '0;
        end else begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
    endcase
    enable_n_d = (state_d != HOST_RUN);
    mod_d = (state_d == HOST_RUN) && (cnt_d < pulse_width);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= HOST_IDLE;
      cnt_q <= '0;
      enable_n_q <= 1'b1;
      mod_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      enable_n_q <= enable_n_d;
      mod_q <= mod_d;
    end
  end

  assign link.enable_n = enable_n_q;
  assign link.modulation = mod_q;
  assign fault_seen = sync2_q[HS_FAULT];
  assign duty_warn = sync2_q[HS_DUTY];
  assign refl_warn = sync2_q[HS_REFL];

endmodule : laser_host

`default_nettype wire

/* File: hw/laser_link_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface laser_link_if;
  logic enable_n;
  logic modulation;
  logic system_fault;
  logic duty_limit_flag;
  logic reflection_limit_flag;

  modport device (
    input enable_n,
    input modulation,
    output system_fault,
    output duty_limit_flag,
    output reflection_limit_flag
  );

  modport host (
    output enable_n,
    output modulation,
    input system_fault,
    input duty_limit_flag,
    input reflection_limit_flag
  );
endinterface : laser_link_if

`default_nettype wire

/* File: hw/laser_pkg.sv */
package laser_pkg;

  // Clock
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_PERIOD_NS = 25;

  // Counter width for pulse width and period measurement
  localparam int unsigned CNT_W = 20;
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  // Longest allowed pulse; truncation point, so the count rounds down
  localparam int unsigned MAX_WIDTH_NS = 1_000_000;
  localparam int unsigned MAX_WIDTH_CYC = MAX_WIDTH_NS / CLK_PERIOD_NS;

  // Duty cycle is width / period * 100, limited to this percentage
  localparam int unsigned DUTY_SCALE = 100;
  localparam int unsigned MAX_DUTY_PCT = 40;

  // Least time the host holds enable released to clear a latched fault
  localparam int unsigned CLEAR_OPEN_NS = 10_000;
  localparam int unsigned CLEAR_OPEN_CYC = (CLEAR_OPEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Bit positions in the device input synchroniser
  localparam int unsigned DS_ENABLE_N = 0;
  localparam int unsigned DS_MOD = 1;
  localparam int unsigned DS_TEMP = 2;
  localparam int unsigned DS_SHUTTER = 3;
  localparam int unsigned DS_REFL = 4;
  localparam int unsigned DS_W = 5;

  // Bit positions in the host input synchroniser
  localparam int unsigned HS_FAULT = 0;
  localparam int unsigned HS_DUTY = 1;
  localparam int unsigned HS_REFL = 2;
  localparam int unsigned HS_POWER = 3;
  localparam int unsigned HS_W = 4;

  // Device run state
  typedef enum logic [3:0] {
    DEV_OFF = 4'b0001,
    DEV_RUN = 4'b0010,
    DEV_FAULT = 4'b0100,
    DEV_ARMED = 4'b1000
  } dev_state_e;

  // Host control state
  typedef enum logic [2:0] {
    HOST_IDLE = 3'b001,
    HOST_RUN = 3'b010,
    HOST_CLEAR = 3'b100
  } host_state_e;

endpackage : laser_pkg

/* File: sim/laser_link_chk.sv */
`timescale 1ns/1ps
`default_nettype none

module laser_link_chk (
  input wire logic clock,
  input wire logic srst,
  input wire logic enable_n,
  input wire logic modulation,
  input wire logic system_fault,
  input wire logic duty_limit_flag,
  input wire logic reflection_limit_flag
);
  // Set once the enable has been seen released during the current fault
  logic rel_q;
  logic rel_d;

  always_comb begin
    rel_d = system_fault & (rel_q | enable_n);
  end

  always_ff @(posedge clock) begin
    rel_q <= srst ? 1'b0 : rel_d;
  end

  default clocking @(posedge clock);
  endclocking
  default disable iff (srst);

  a_mod_gated: assert property (enable_n |-> !modulation)
    else $error("pulse command while enable released");
  a_duty_idle_low: assert property (duty_limit_flag |-> $past(modulation, 3))
    else $error("duty flag without pulse command");
  a_refl_idle_low: assert property (!modulation |-> ##3 !reflection_limit_flag)
    else $error("reflection flag without pulse command");
  a_duty_needs_width: assert property ($rose(duty_limit_flag) |-> $past(modulation, 4))
    else $error("duty flag rose on a fresh pulse");
  a_refl_off_released: assert property (enable_n [*8] |-> ##3 !reflection_limit_flag)
    else $error("reflection flag while released");
  a_fault_clear_seq: assert property ($fell(system_fault) |-> rel_q)
    else $error("fault cleared without release");
  a_fault_clear_enabled: assert property ($fell(system_fault) |-> !$past(enable_n, 3))
    else $error("fault cleared while released");
  a_fault_hold: assert property (system_fault && $rose(enable_n) |=> system_fault [*3])
    else $error("fault dropped on release");

  c_duty: cover property ($rose(duty_limit_flag));
  c_refl: cover property ($rose(reflection_limit_flag));
  c_clear: cover property ($fell(system_fault));
endmodule : laser_link_chk

`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clock = 0;
  logic srst = 1;
  logic power_ok = 0;
  logic run_req = 0;
  logic clear_req = 0;
  logic temp_fault = 0;
  logic shutter_fault = 0;
  logic refl_over = 0;
  logic [laser_pkg::CNT_W-1:0] pulse_width = '0;
  logic [laser_pkg::CNT_W-1:0] pulse_period = '0;
  logic laser_on, fault_seen, duty_warn, refl_warn;
  int n_mismatch = 0;
  int comparisons = 0;

  laser_link_if link ();
  laser_device #(.max_width_cycles(50)) laser_device_inst (.clock(clock), .srst(srst),
    .link(link), .temp_fault(temp_fault), .shutter_fault(shutter_fault),
    .refl_over(refl_over), .laser_on(laser_on));
  laser_host laser_host_inst (.clock(clock), .srst(srst), .link(link),
    .power_ok(power_ok), .run_req(run_req), .clear_req(clear_req),
    .pulse_width(pulse_width), .pulse_period(pulse_period), .fault_seen(fault_seen),
    .duty_warn(duty_warn), .refl_warn(refl_warn));
  laser_link_chk laser_link_chk_inst (.clock(clock), .srst(srst),
    .enable_n(link.enable_n), .modulation(link.modulation),
    .system_fault(link.system_fault), .duty_limit_flag(link.duty_limit_flag),
    .reflection_limit_flag(link.reflection_limit_flag));

  initial begin
    forever #12.5 clock = ~clock;
  end

  task automatic check(input bit ok, input string m);
    comparisons++;
    if (!ok) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : check

  // Restart the host so new settings begin on a clean period
  task automatic start(input int w, input int p);
    @(posedge clock);
    run_req <= 1'b0;
    repeat (5) @(posedge clock);
    pulse_width <= 20'(w);
    pulse_period <= 20'(p);
    run_req <= 1'b1;
  endtask : start

  // Counts over the second pulse, the first may overlap run entry
  task automatic measure(input int n, output int on, output int dl, output int rf,
                         output int wn);
    on = 0;
    dl = 0;
    rf = 0;
    wn = 0;
    repeat (2) @(posedge link.modulation);
    repeat (n) begin
      @(negedge clock);
      on += (laser_on === 1'b1);
      dl += (link.duty_limit_flag === 1'b1);
      rf += (link.reflection_limit_flag === 1'b1);
      wn += (duty_warn === 1'b1 || refl_warn === 1'b1);
    end
  endtask : measure

  // Host must hold enable released until the supply is seen up
  task automatic t_supply();
    run_req <= 1'b1;
    repeat (20) @(posedge clock);
    @(negedge clock);
    check(link.enable_n === 1'b1, "enable before supply");
    @(posedge clock);
    power_ok <= 1'b1;
    repeat (6) @(posedge clock);
    @(negedge clock);
    check(link.enable_n === 1'b0, "enable after supply");
    $display("supply test done");
  endtask : t_supply

  task automatic t_limits();
    int on, dl, rf, wn;
    start(10, 100);
    measure(60, on, dl, rf, wn);
    check(on == 10, "plain pulse");
    check(dl + rf + wn == 0, "flags on plain pulse");
    start(80, 1000);
    measure(120, on, dl, rf, wn);
    check(on == 50, "truncation");
    check(dl == 30 && wn == 30, "width flag span");
    start(45, 60);
    measure(55, on, dl, rf, wn);
    check(on == 24, "duty cut point");
    check(dl == 21 && wn == 21, "duty flag span");
    @(posedge clock);
    refl_over <= 1'b1;
    start(10, 100);
    measure(60, on, dl, rf, wn);
    @(posedge clock);
    refl_over <= 1'b0;
    check(rf == 10 && wn == 10, "reflection flag span");
    check(on == 0, "reflection inhibit");
    $display("limit tests done");
  endtask : t_limits

  task automatic t_fault(input int i);
    int on, dl, rf, wn;
    start(10, 100);
    measure(60, on, dl, rf, wn);
    @(posedge clock);
    temp_fault <= (i == 0);
    shutter_fault <= (i == 1);
    repeat (5) @(posedge clock);
    temp_fault <= 1'b0;
    shutter_fault <= 1'b0;
    repeat (20) @(posedge clock);
    @(negedge clock);
    check(link.system_fault === 1'b1 && fault_seen === 1'b1, "fault latch");
    measure(60, on, dl, rf, wn);
    check(on == 0, "shut down");
    @(posedge clock);
    clear_req <= 1'b1;
    @(posedge clock);
    clear_req <= 1'b0;
    repeat (600) @(posedge clock);
    @(negedge clock);
    check(link.system_fault === 1'b0, "fault clear");
    measure(60, on, dl, rf, wn);
    check(on == 10, "resume");
    $display("fault test %0d done", i);
  endtask : t_fault

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (40000) @(posedge clock);
    n_mismatch++;
    stop_test();
  end

  initial begin
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    t_supply();
    t_limits();
    for (int i = 0; i < 2; i++) begin
      t_fault(i);
    end
    stop_test();
  end
endmodule : tb_top

`default_nettype wire
